// ===== hw/lpd_cfg.svh
`ifndef LPD_CFG_SVH
`define LPD_CFG_SVH
`define LPD_CHANNELS        48
`define LPD_GS_WIDTH        16
`define LPD_DC_WIDTH        7
`define LPD_GS_LATCH_BITS   768
`define LPD_DC_LATCH_BITS   336
`define LPD_CTRL_LATCH_BITS 371
`define LPD_SEGMENTS        128
`define LPD_SEG_CLOCKS      512
`define LPD_SEG_BITS        9
`define LPD_SEGNUM_BITS     7
`define LPD_PERIOD_BITS     16
`endif

// ===== hw/lpd_pkg.sv
package lpd_pkg;
    typedef enum logic [1:0]
    {
        LPD_IDLE    = 2'b00,
        LPD_RUN     = 2'b01,
        LPD_PENDING = 2'b11
    } lpd_state_type;
endpackage

// ===== hw/lpd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lpd_sync
(
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== hw/lpd_display.sv
`include "lpd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lpd_display
#(
    parameter int CHANNELS = `LPD_CHANNELS
)
(
    input  wire logic                                   clk_in,
    input  wire logic                                   rst_b_in,
    input  wire logic                                   grayscale_clock_in,
    input  wire logic                                   latch_pulse_in,
    input  wire logic                                   gs_write_in,
    input  wire logic                                   repeat_enable_bit_in,
    input  wire logic                                   timing_reset_enable_bit_in,
    input  wire logic                                   auto_refresh_enable_bit_in,
    input  wire logic [CHANNELS*`LPD_GS_WIDTH-1:0]      shift_register_in,
    input  wire logic [CHANNELS*`LPD_DC_WIDTH-1:0]      control_dc_in,
    output var  logic [CHANNELS-1:0]                    sink_output_out,
    output var  logic [CHANNELS*`LPD_GS_WIDTH-1:0]      grayscale_value_out,
    output var  logic [CHANNELS*`LPD_DC_WIDTH-1:0]      dot_correction_value_out,
    output var  logic                                   refresh_pending_out,
    output var  logic                                   period_active_out
);
    import lpd_pkg::*;

    // The logic serves any channel count of one or more; the latch widths follow from it.
    if (CHANNELS < 1)
    begin : g_bad_channels
        $error("CHANNELS must be at least one");
    end

    logic grayscale_clock_sync;
    logic grayscale_clock_prev;
    logic lat_sync;
    logic lat_prev;
    logic [`LPD_PERIOD_BITS-1:0] count;
    lpd_state_type state;
    lpd_state_type next_state;

    lpd_sync u_grayscale_clock_sync
    (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .async_in (grayscale_clock_in),
        .sync_out (grayscale_clock_sync)
    );

    lpd_sync u_lat_sync
    (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .async_in (latch_pulse_in),
        .sync_out (lat_sync)
    );

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            grayscale_clock_prev <= 1'b0;
            lat_prev   <= 1'b0;
        end
        else
        begin
            grayscale_clock_prev <= grayscale_clock_sync;
            lat_prev   <= lat_sync;
        end
    end

    // The grayscale-write qualifier is sampled on the same edge as the synchronised latch pulse.
    wire gs_tick     = grayscale_clock_sync & ~grayscale_clock_prev;
    wire lat_rise    = lat_sync & ~lat_prev;
    wire gs_lat      = lat_rise & gs_write_in;
    wire tmg_reset   = gs_lat & timing_reset_enable_bit_in;
    wire running     = (state != LPD_IDLE);
    wire period_end  = running & gs_tick & (count == {`LPD_PERIOD_BITS{1'b1}});
    wire defer       = auto_refresh_enable_bit_in & ~timing_reset_enable_bit_in;
    wire load_now    = gs_lat & ~defer;
    wire load_end    = period_end & (state == LPD_PENDING);
    wire load_latch  = load_now | load_end;
    wire pend_set    = gs_lat & defer;

    always_comb
    begin
        next_state = state;
        case (state)
            LPD_IDLE:
            begin
                if (tmg_reset)
                    next_state = LPD_RUN;
                else if (repeat_enable_bit_in)
                    next_state = LPD_RUN;
            end
            LPD_RUN:
            begin
                if (pend_set)
                    next_state = LPD_PENDING;
                else if (period_end && !repeat_enable_bit_in && !tmg_reset)
                    next_state = LPD_IDLE;
            end
            LPD_PENDING:
            begin
                if (period_end)
                    next_state = repeat_enable_bit_in ? LPD_RUN : LPD_IDLE;
            end
            default:
                next_state = LPD_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            state <= LPD_IDLE;
        else
            state <= next_state;
    end

    // The counter runs through 128 segments of 512 grayscale clocks and wraps at period end.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            count <= '0;
        else if (tmg_reset)
            count <= '0;
        else if (running && gs_tick)
            count <= count + 1'b1;
    end

    // Pending values stay upstream, so the deferred copy reads the sources directly.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            grayscale_value_out      <= '0;
            dot_correction_value_out <= '0;
        end
        else if (load_latch)
        begin
            grayscale_value_out      <= shift_register_in;
            dot_correction_value_out <= control_dc_in;
        end
    end

    wire [`LPD_SEG_BITS-1:0]    seg_pos = count[`LPD_SEG_BITS-1:0];
    wire [`LPD_SEGNUM_BITS-1:0] seg_num = count[`LPD_PERIOD_BITS-1:`LPD_SEG_BITS];

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : g_chan
            wire [`LPD_GS_WIDTH-1:0]    gs   = grayscale_value_out[ch*`LPD_GS_WIDTH +: `LPD_GS_WIDTH];
            wire [`LPD_SEG_BITS-1:0]    base = gs[`LPD_GS_WIDTH-1:`LPD_SEGNUM_BITS];
            wire [`LPD_SEGNUM_BITS-1:0] low  = gs[`LPD_SEGNUM_BITS-1:0];
            // Spread the low bits: one extra clock in segments whose bit-reversed index is below low.
            wire [`LPD_SEGNUM_BITS-1:0] rev  = {<<{seg_num}};
            wire [`LPD_SEG_BITS:0]      len  = {1'b0, base} + {{`LPD_SEG_BITS{1'b0}}, (rev < low)};
            wire                        on   = running && !tmg_reset && ({1'b0, seg_pos} < len);
            always_ff @(posedge clk_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                    sink_output_out[ch] <= 1'b0;
                else
                    sink_output_out[ch] <= on;
            end
        end
    endgenerate

    assign refresh_pending_out = (state == LPD_PENDING);
    assign period_active_out   = running;

    tmg_reset_clears_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        tmg_reset |=> (count == '0) && (sink_output_out == '0))
        else $error("timing reset did not clear counter and outputs");
    no_reset_keeps_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        gs_lat && !timing_reset_enable_bit_in && running && !gs_tick |=> count == $past(count))
        else $error("latch edge disturbed counter without timing reset");
    load_now_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        load_now |=> grayscale_value_out == $past(shift_register_in))
        else $error("grayscale latch not loaded at latch edge");
    defer_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !load_latch |=> $stable(grayscale_value_out) && $stable(dot_correction_value_out))
        else $error("active latches changed while deferred");
    end_copy_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        load_end |=> dot_correction_value_out == $past(control_dc_in) && !refresh_pending_out)
        else $error("pending values not copied at period end");
    count_only_tick_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !gs_tick && !tmg_reset |=> $stable(count))
        else $error("counter moved without grayscale clock");
    repeat_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        period_end && repeat_enable_bit_in |=> period_active_out)
        else $error("period did not repeat");
    single_shot_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !running && !tmg_reset && !repeat_enable_bit_in |=> ##1 sink_output_out == '0)
        else $error("outputs on after single shot");
    one_shot_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        period_end && !repeat_enable_bit_in && !tmg_reset && !pend_set |=> !period_active_out)
        else $error("single shot did not stop");

    cover_repeat_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) period_end && repeat_enable_bit_in);
    cover_tmg_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) tmg_reset && running);
    cover_defer_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) load_end);
    cover_single_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) period_end && !repeat_enable_bit_in);
endmodule
`default_nettype wire

// ===== verification/lpd_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpd_ctrl_model
(
    input  wire logic clk_in,
    output var  logic grayscale_clock_out,
    output var  logic latch_pulse_out
);
    initial
    begin
        grayscale_clock_out = 1'b0;
        latch_pulse_out     = 1'b0;
    end

    // Each tick stays high for three cycles and low for three; the clock rests low between bursts.
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(negedge clk_in);
            grayscale_clock_out = 1'b1;
            repeat (3) @(negedge clk_in);
            grayscale_clock_out = 1'b0;
            repeat (2) @(negedge clk_in);
        end
    endtask

    task automatic latch();
        @(negedge clk_in);
        latch_pulse_out = 1'b1;
        repeat (4) @(negedge clk_in);
        latch_pulse_out = 1'b0;
        repeat (6) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// ===== verification/test_led_pwm_display_period_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_led_pwm_display_period_control;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        grayscale_clock, lat;
    logic        gs_wr = 1'b0, rpt = 1'b0, tmr = 1'b0, rfr = 1'b0;
    logic [63:0] sr = '0;
    logic [27:0] dc = '0;
    logic [3:0]  sink;
    logic [63:0] gsv;
    logic [27:0] dcv;
    logic        pend, act;
    int          err_count = 0, check_count = 0, cyc = 0;

    lpd_ctrl_model lpd_ctrl_model_inst (.clk_in(clk_in), .grayscale_clock_out(grayscale_clock), .latch_pulse_out(lat));
    lpd_display #(.CHANNELS(4)) lpd_display_inst
    (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .grayscale_clock_in(grayscale_clock), .latch_pulse_in(lat),
        .gs_write_in(gs_wr), .repeat_enable_bit_in(rpt), .timing_reset_enable_bit_in(tmr),
        .auto_refresh_enable_bit_in(rfr), .shift_register_in(sr), .control_dc_in(dc),
        .sink_output_out(sink), .grayscale_value_out(gsv), .dot_correction_value_out(dcv),
        .refresh_pending_out(pend), .period_active_out(act)
    );

    always #20 clk_in = ~clk_in;

    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            results();
        end
    end

    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk_in);
        rst_b_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_b_in = 1'b1;
    endtask

    task automatic chk_idle();
        tmr = 1'b1;
        sr = 64'hffff_0000_ffff_0000;
        lpd_ctrl_model_inst.latch();
        cmp("ignored_gs", 64'h0, gsv);
        lpd_ctrl_model_inst.ticks(2);
        cmp("idle_active", 64'h0, act);
        cmp("idle_sink", 64'h0, sink);
    endtask

    task automatic chk_timing_reset();
        dc = 28'h5a5a5a5;
        gs_wr = 1'b1;
        lpd_ctrl_model_inst.latch();
        cmp("gs_latch", sr, gsv);
        cmp("dc_latch", {36'h0, dc}, dcv);
        cmp("active", 64'h1, act);
        lpd_ctrl_model_inst.ticks(3);
        cmp("sink_full", 64'ha, sink);
    endtask

    task automatic chk_no_reset();
        tmr = 1'b0;
        dc = 28'h1234567;
        sr = 64'hffff_0000_fffe_0000;
        fork
            lpd_ctrl_model_inst.latch();
            repeat (10)
            begin
                @(negedge clk_in);
                cmp("sink_kept", 64'ha, sink);
            end
        join
        cmp("gs_direct", sr, gsv);
        cmp("dc_direct", {36'h0, dc}, dcv);
    endtask

    task automatic chk_refresh();
        rfr = 1'b1;
        dc = 28'h0abcdef;
        sr = 64'h0000_ffff_0000_ffff;
        repeat (2)
        begin
            lpd_ctrl_model_inst.latch();
            cmp("pending", 64'h1, pend);
            cmp("gs_held", 64'hffff_0000_fffe_0000, gsv);
            cmp("dc_held", 64'h1234567, dcv);
        end
        lpd_ctrl_model_inst.ticks(2);
        cmp("sink_old", 64'ha, sink);
    endtask

    task automatic chk_repeat();
        rfr = 1'b0;
        rpt = 1'b1;
        do_reset();
        repeat (4) @(negedge clk_in);
        cmp("repeat_run", 64'h1, act);
        cmp("reset_gs", 64'h0, gsv);
    endtask

    initial
    begin
        do_reset();
        chk_idle();
        chk_timing_reset();
        chk_no_reset();
        chk_refresh();
        chk_repeat();
        results();
    end
endmodule
`default_nettype wire
